// *** src/pulse_timer_and_counters.sv ***
/*
  Pulse timer, up counter and down counter as clocked logic.
  Assumes the controller program drives inputs synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Input rising starts the pulse timer and sets its output.
// - When elapsed equals preset, output drops and timing stops.
// - Input falling early does not stop timing; output stays high.
// - Elapsed and output clear at expiry with input low, or input fall.
// - Up counter adds one per count-up rising edge, 32-bit unsigned.
// - Up counter done is high when count equals preset and clear is low.
// - Up counter holds at preset and ignores further edges.
// - Up counter clear input zeroes count and drops done.
// - Up counter does not count while clear is high.
// - Down counter loads preset when load input falls.
// - Down counter subtracts one per count-down rising edge.
// - Down counter done is high when count is zero.
// - Down counter ignores edges while load is high.
// - Count-down edge at zero leaves count and done unchanged.
module pulse_timer_and_counters #(
  parameter int TICKS_PER_UNIT = ptc_pkg::TICKS_PER_UNIT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pulse timer
  input wire logic pulseTimerInput,
  input wire logic [ptc_pkg::TIME_W-1:0] presetTime,
  output logic pulseTimerOutput,
  output logic [ptc_pkg::TIME_W-1:0] elapsedTime,
  // Up counter
  input wire ptc_pkg::up_req_t upReq,
  output logic upDone,
  output logic [ptc_pkg::COUNT_W-1:0] upCountValue,
  // Down counter
  input wire ptc_pkg::down_req_t downReq,
  output logic downDone,
  output logic [ptc_pkg::COUNT_W-1:0] downCountValue
);
  localparam logic [ptc_pkg::TICK_W-1:0] TICK_LAST =
    ptc_pkg::TICK_W'(TICKS_PER_UNIT - 1);

  logic rstMeta_b;
  logic rstSync_b;
  logic timerRise, timerFall, upRise, downRise, loadFall;
  logic [ptc_pkg::TICK_W-1:0] tick;
  ptc_pkg::pulse_state_t timerState;
  logic [ptc_pkg::COUNT_W-1:0] next_up;
  logic [ptc_pkg::COUNT_W-1:0] next_down;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // One detector per edge-sensitive input, none for clear; load only needs its fall
  edge_detect uTimer (.clk_sys(clk_sys), .rstSync_b(rstSync_b),
    .level(pulseTimerInput), .rise(timerRise), .fall(timerFall));
  edge_detect uUp (.clk_sys(clk_sys), .rstSync_b(rstSync_b),
    .level(upReq.countUpInput), .rise(upRise), .fall());
  edge_detect uDown (.clk_sys(clk_sys), .rstSync_b(rstSync_b),
    .level(downReq.countDownInput), .rise(downRise), .fall());
  edge_detect uLoad (.clk_sys(clk_sys), .rstSync_b(rstSync_b),
    .level(downReq.load), .rise(), .fall(loadFall));

  // Pulse timer: once started it runs to preset regardless of input
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      timerState <= ptc_pkg::TIMER_IDLE;
      tick <= ptc_pkg::TICK_ZERO;
      elapsedTime <= ptc_pkg::TIME_ZERO;
      pulseTimerOutput <= 1'b0;
    end else begin
      unique case (timerState)
        ptc_pkg::TIMER_IDLE: begin
          if (timerRise) begin
            timerState <= ptc_pkg::TIMER_RUN;
            pulseTimerOutput <= 1'b1;
            tick <= ptc_pkg::TICK_ZERO;
            elapsedTime <= ptc_pkg::TIME_ZERO;
          end
        end
        ptc_pkg::TIMER_RUN: begin
          if (elapsedTime >= presetTime) begin
            pulseTimerOutput <= 1'b0;
            if (pulseTimerInput) begin
              timerState <= ptc_pkg::TIMER_EXPIRED;
            end else begin
              timerState <= ptc_pkg::TIMER_IDLE;
              elapsedTime <= ptc_pkg::TIME_ZERO;
            end
          end else if (tick == TICK_LAST) begin
            // Input level ignored here, so an early fall keeps timing
            tick <= ptc_pkg::TICK_ZERO;
            elapsedTime <= elapsedTime + ptc_pkg::TIME_ONE;
          end else begin
            tick <= tick + ptc_pkg::TICK_ONE;
          end
        end
        ptc_pkg::TIMER_EXPIRED: begin
          if (timerFall) begin
            timerState <= ptc_pkg::TIMER_IDLE;
            elapsedTime <= ptc_pkg::TIME_ZERO;
          end
        end
      endcase
    end
  end

  // Up counter next value: clear beats edges, stops at preset
  always_comb begin
    next_up = upCountValue;
    if (upReq.clear) begin
      next_up = ptc_pkg::COUNT_ZERO;
    end else if (upRise && upCountValue != upReq.presetValue) begin
      next_up = upCountValue + ptc_pkg::COUNT_ONE;
    end
  end

  // Up counter state; done is registered from next_up, in step with the count
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      upCountValue <= ptc_pkg::COUNT_ZERO;
      upDone <= 1'b0;
    end else begin
      upCountValue <= next_up;
      upDone <= (next_up == upReq.presetValue) && !upReq.clear;
    end
  end

  // Down counter next value: load fall copies preset, zero holds
  always_comb begin
    next_down = downCountValue;
    if (loadFall) begin
      next_down = downReq.presetValue;
    end else if (downRise && !downReq.load &&
                 downCountValue != ptc_pkg::COUNT_ZERO) begin
      next_down = downCountValue - ptc_pkg::COUNT_ONE;
    end
  end

  // Down counter state
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      downCountValue <= ptc_pkg::COUNT_ZERO;
      downDone <= 1'b0;
    end else begin
      downCountValue <= next_down;
      downDone <= (next_down == ptc_pkg::COUNT_ZERO);
    end
  end

  // Checks; done flags lag the count by one edge out of reset, so the
  // flag checks wait until the internal reset was seen high last edge
  a_pulse_starts: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_IDLE && timerRise) |=> pulseTimerOutput)
    else $error("pulse did not start");
  a_pulse_ends: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_RUN && elapsedTime >= presetTime)
    |=> !pulseTimerOutput)
    else $error("pulse did not end at preset");
  a_pulse_holds: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_RUN && elapsedTime < presetTime)
    |=> pulseTimerOutput)
    else $error("pulse dropped early");
  a_pulse_clears: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_EXPIRED && timerFall)
    |=> elapsedTime == ptc_pkg::TIME_ZERO)
    else $error("elapsed not cleared");
  a_pulse_idles: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_RUN && elapsedTime >= presetTime &&
     !pulseTimerInput) |=> elapsedTime == ptc_pkg::TIME_ZERO)
    else $error("elapsed not cleared at expiry");
  a_timer_ticks: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (timerState == ptc_pkg::TIMER_RUN && elapsedTime < presetTime &&
     tick == TICK_LAST)
    |=> elapsedTime == $past(elapsedTime) + ptc_pkg::TIME_ONE)
    else $error("elapsed did not step");
  a_up_counts: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (upRise && !upReq.clear && upCountValue != upReq.presetValue)
    |=> upCountValue == $past(upCountValue) + ptc_pkg::COUNT_ONE)
    else $error("up count missed an edge");
  a_up_done: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    ($past(rstSync_b) && !upReq.clear && !$past(upReq.clear) &&
     $stable(upReq.presetValue))
    |-> upDone == (upCountValue == upReq.presetValue))
    else $error("up done wrong");
  a_up_holds: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (!upReq.clear && upCountValue == upReq.presetValue)
    |=> $stable(upCountValue))
    else $error("up count passed preset");
  a_up_cleared: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    upReq.clear |=> upCountValue == ptc_pkg::COUNT_ZERO && !upDone)
    else $error("up clear failed");
  a_down_loads: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    loadFall |=> downCountValue == $past(downReq.presetValue))
    else $error("down load failed");
  a_down_counts: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (downRise && !downReq.load && !loadFall &&
     downCountValue != ptc_pkg::COUNT_ZERO)
    |=> downCountValue == $past(downCountValue) - ptc_pkg::COUNT_ONE)
    else $error("down count missed an edge");
  a_down_done: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    $past(rstSync_b) |-> downDone == (downCountValue == ptc_pkg::COUNT_ZERO))
    else $error("down done wrong");
  a_down_gated: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    (downReq.load && !loadFall) |=> $stable(downCountValue))
    else $error("down counted during load");
  a_down_floor: assert property (
    @(posedge clk_sys) disable iff (!rstSync_b)
    ($past(rstSync_b) && downCountValue == ptc_pkg::COUNT_ZERO && !loadFall)
    |=> downCountValue == ptc_pkg::COUNT_ZERO && downDone)
    else $error("down count wrapped");
endmodule
`default_nettype wire

// *** src/ptc_pkg.sv ***
/*
  Shared types and constants for the pulse timer and the two counters.
  Assumes one 50 MHz system clock and synchronous instruction inputs.
*/
package ptc_pkg;
  localparam int COUNT_W = 32;
  localparam int TIME_W = 32;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [TIME_W-1:0] TIME_ZERO = 32'h0000_0000;
  localparam logic [TIME_W-1:0] TIME_ONE = 32'h0000_0001;
  // Clock rate and time unit (1000 microseconds, so milliseconds)
  localparam int CLK_HZ = 50000000;
  localparam int UNIT_US = 1000;
  localparam int TICKS_PER_UNIT = CLK_HZ / 1000000 * UNIT_US;
  localparam int TICK_W = 32;
  localparam logic [TICK_W-1:0] TICK_ZERO = 32'h0000_0000;
  localparam logic [TICK_W-1:0] TICK_ONE = 32'h0000_0001;

  typedef enum logic [1:0] {
    TIMER_IDLE,
    TIMER_RUN,
    TIMER_EXPIRED
  } pulse_state_t;

  typedef struct packed {
    logic countUpInput;
    logic clear;
    logic [COUNT_W-1:0] presetValue;
  } up_req_t;

  typedef struct packed {
    logic countDownInput;
    logic load;
    logic [COUNT_W-1:0] presetValue;
  } down_req_t;
endpackage

// *** src/edge_detect.sv ***
/*
  Rising and falling edge detector for one synchronous level.
  Assumes the level is already synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstSync_b,
  // Level in, edges out
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last;

  // Previous sample, cleared on reset
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule
`default_nettype wire

// *** bench/program_model.sv ***
/*
  Model of the controller program that drives the instruction inputs.
  Assumes the bench presents wanted levels; one scan per clk_sys edge.
*/
`timescale 1ns/10ps
`default_nettype none
module program_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wanted levels from the bench
  input wire logic wantTimer,
  input wire logic [ptc_pkg::TIME_W-1:0] wantTime,
  input wire ptc_pkg::up_req_t wantUp,
  input wire ptc_pkg::down_req_t wantDown,
  // Instruction inputs of the block
  output logic pulseTimerInput,
  output logic [ptc_pkg::TIME_W-1:0] presetTime,
  output var ptc_pkg::up_req_t upReq,
  output var ptc_pkg::down_req_t downReq
);
  // One program scan a cycle, so all inputs move on the same edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulseTimerInput <= 1'b0;
      presetTime <= ptc_pkg::TIME_ZERO;
      upReq <= '0;
      downReq <= '0;
    end else begin
      pulseTimerInput <= wantTimer;
      presetTime <= wantTime;
      upReq <= wantUp;
      downReq <= wantDown;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_pulse_timer_and_counters.sv ***
/*
  Self-checking bench for the pulse timer and the two counters.
  Assumes TICKS_PER_UNIT can be shortened to 2 for simulation.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_pulse_timer_and_counters;
  localparam int TPU = 2;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wantTimer = 1'b0;
  logic [31:0] wantTime = 32'h0000_0001;
  ptc_pkg::up_req_t wantUp = '0;
  ptc_pkg::down_req_t wantDown = '0;
  logic pulseTimerInput;
  logic [31:0] presetTime;
  ptc_pkg::up_req_t upReq;
  ptc_pkg::down_req_t downReq;
  logic pulseTimerOutput;
  logic upDone;
  logic downDone;
  logic [31:0] elapsedTime;
  logic [31:0] upCountValue;
  logic [31:0] downCountValue;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] seed = 8'h22;
  int preset;
  int dur;
  always #10 clk_sys = ~clk_sys;
  program_model partner (.clk_sys(clk_sys), .rst_b(rst_b),
    .wantTimer(wantTimer), .wantTime(wantTime), .wantUp(wantUp),
    .wantDown(wantDown), .pulseTimerInput(pulseTimerInput),
    .presetTime(presetTime), .upReq(upReq), .downReq(downReq));
  pulse_timer_and_counters #(.TICKS_PER_UNIT(TPU)) dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .pulseTimerInput(pulseTimerInput),
    .presetTime(presetTime), .pulseTimerOutput(pulseTimerOutput),
    .elapsedTime(elapsedTime), .upReq(upReq), .upDone(upDone),
    .upCountValue(upCountValue), .downReq(downReq), .downDone(downDone),
    .downCountValue(downCountValue));
  // Small LFSR keeps the random presets repeatable
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic checkVal(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp,
                          input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // One clean count edge, low again before the result is read
  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) wantUp.countUpInput <= 1'b1;
    else wantDown.countDownInput <= 1'b1;
    tick(1);
    wantUp.countUpInput <= 1'b0;
    wantDown.countDownInput <= 1'b0;
    tick(3);
    @(negedge clk_sys);
  endtask
  // Bounded wait on the timer output, counted in whole cycles
  task automatic waitOut(input logic lvl, input int bound, output int n);
    n = 0;
    while (pulseTimerOutput !== lvl && n < bound) begin
      @(negedge clk_sys);
      n++;
    end
    if (pulseTimerOutput !== lvl) begin
      mismatches++;
      $display("MISMATCH timer wait expected %b seen %b", lvl, ~lvl);
      test_done();
    end
  endtask
  task automatic test_done;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    tick(20000);
    mismatches++;
    $display("MISMATCH run length expected done seen running");
    test_done();
  end
  initial begin
    tick(2);
    rst_b <= 1'b1;
    tick(4);
    @(negedge clk_sys);
    checkVal("upCountValue", 32'h0000_0000, upCountValue);
    checkBit("pulseTimerOutput", 1'b0, pulseTimerOutput);
    checkBit("downDone", 1'b1, downDone);
    repeat (2) begin
      seed = lfsrNext(seed);
      preset = 2 + int'(seed[1:0]);
      @(posedge clk_sys);
      wantUp.presetValue <= 32'(preset);
      wantDown.presetValue <= 32'(preset);
      wantTime <= 32'(preset);
      for (int i = 1; i <= preset + 2; i++) begin
        pulse(0);
        checkVal("upCountValue", 32'(i < preset ? i : preset), upCountValue);
        checkBit("upDone", i >= preset, upDone);
      end
      @(posedge clk_sys);
      wantUp.clear <= 1'b1;
      pulse(0);
      checkVal("upCountValue", 32'h0000_0000, upCountValue);
      checkBit("upDone", 1'b0, upDone);
      @(posedge clk_sys);
      wantUp.clear <= 1'b0;
      wantDown.load <= 1'b1;
      tick(2);
      wantDown.load <= 1'b0;
      tick(4);
      @(negedge clk_sys);
      checkVal("downCountValue", 32'(preset), downCountValue);
      pulse(1);
      checkVal("downCountValue", 32'(preset - 1), downCountValue);
      @(posedge clk_sys);
      wantDown.load <= 1'b1;
      pulse(1);
      checkVal("downCountValue", 32'(preset - 1), downCountValue);
      @(posedge clk_sys);
      wantDown.load <= 1'b0;
      tick(4);
      @(negedge clk_sys);
      checkVal("downCountValue", 32'(preset), downCountValue);
      for (int i = preset - 1; i >= -1; i--) begin
        pulse(1);
        checkVal("downCountValue", 32'(i < 0 ? 0 : i), downCountValue);
        checkBit("downDone", i <= 0, downDone);
      end
      // Long pulse with the input held through expiry
      @(posedge clk_sys);
      wantTimer <= 1'b1;
      waitOut(1'b1, 10, dur);
      waitOut(1'b0, 4 * TPU * preset + 20, dur);
      checkBit("pulse length", dur >= TPU * preset && dur <= TPU * preset + 2, 1'b1);
      checkVal("elapsedTime", 32'(preset), elapsedTime);
      @(posedge clk_sys);
      wantTimer <= 1'b0;
      tick(4);
      @(negedge clk_sys);
      checkVal("elapsedTime", 32'h0000_0000, elapsedTime);
      // Short input pulse still keeps the output high after the input falls, then it drops
      @(posedge clk_sys);
      wantTimer <= 1'b1;
      tick(1);
      wantTimer <= 1'b0;
      tick(5);
      @(negedge clk_sys);
      checkBit("pulseTimerOutput", 1'b1, pulseTimerOutput);
      waitOut(1'b0, 4 * TPU * preset + 20, dur);
      tick(2);
      @(negedge clk_sys);
      checkVal("elapsedTime", 32'h0000_0000, elapsedTime);
    end
    test_done();
  end
endmodule
`default_nettype wire
